// *** pkg/phy_mac_pkg.sv ***
/*
  constants, types and register map for the mac-side strap and status logic.
  assumes a 10 MHz core clock and an axi4-lite master with 32-bit data.
*/
`default_nettype none

package phy_mac_pkg;

  // ---------------------------------------------------------------
  // bus
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]  STRAP_OFFSET    = 8'h04;
  localparam logic [7:0]  LINE_OFFSET     = 8'h08;
  localparam logic [7:0]  IRQ_STAT_OFFSET = 8'h0c;
  localparam logic [7:0]  IRQ_MASK_OFFSET = 8'h10;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int          CTRL_FULL_DUPLEX_BIT = 0;
  localparam logic [31:0] CTRL_RESET           = 32'h0000_0000;
  localparam int          IRQ_W                = 4;
  localparam int          IRQ_RX_ERR_BIT       = 0;
  localparam int          IRQ_COL_BIT          = 1;
  localparam int          IRQ_CRS_BIT          = 2;
  localparam int          IRQ_STRAP_BIT        = 3;
  localparam logic [3:0]  IRQ_RESET            = 4'h0;
  localparam int          STRAP_MODE_LSB       = 4;
  localparam int          STRAP_LONG_RST_BIT   = 7;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS        = 100;
  localparam int          RESET_HOLD_MS        = 200;
  localparam int          RESET_HOLD_CYCLES    = (RESET_HOLD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int          RESET_CNT_W          = 21;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_MII    = 3'b001,
    MODE_SERIAL = 3'b010,
    MODE_RMII   = 3'b100
  } if_mode_t;

  typedef struct packed {
    logic repeater;
    logic serial;
    logic rmii;
    logic float_out;
  } strap_t;

  localparam strap_t STRAP_RESET = 4'h0;

  typedef struct packed {
    logic crs;
    logic col;
    logic rx_err;
    logic rx_dv;
  } mac_out_t;

  localparam mac_out_t MAC_OUT_RESET = 4'h0;

endpackage

`default_nettype wire

// *** hw/pin_sync3.sv ***
/*
  three-stage synchroniser with agreement filter for pin-level inputs.
  assumes the input is a slow level; a change counts when stage two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter int         WIDTH = 1,
  parameter logic [0:0] INIT  = 1'b0
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] q_reg;

  // first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s1_reg <= {WIDTH{INIT}};
      s2_reg <= {WIDTH{INIT}};
      s3_reg <= {WIDTH{INIT}};
    end else begin
      s1_reg <= i_d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // per-bit agreement keeps a one-cycle glitch out
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q_reg <= {WIDTH{INIT}};
    end else begin
      q_reg <= (s2_reg & s3_reg) | (q_reg & (s2_reg | s3_reg));
    end
  end

  assign o_q = q_reg;

endmodule

`default_nettype wire

// *** hw/phy_mac_side.sv ***
/*
  mac-facing strap capture, receive error, collision and carrier sense logic,
  with an axi4-lite register slave and a level interrupt.
  assumes the phy core drives the medium-side inputs on I_CLK; straps, reset pin
  and the mac transmit pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module phy_mac_side #(
  parameter int RESET_HOLD = phy_mac_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic                      I_CLK,
  input  wire logic                      I_RESET,
  // axi4-lite slave
  input  wire logic                      I_AWVALID,
  output logic                           O_AWREADY,
  input  wire logic [phy_mac_pkg::ADDR_W-1:0] I_AWADDR,
  input  wire logic                      I_WVALID,
  output logic                           O_WREADY,
  input  wire logic [phy_mac_pkg::DATA_W-1:0] I_WDATA,
  input  wire logic [3:0]                I_WSTRB,
  output logic                           O_BVALID,
  input  wire logic                      I_BREADY,
  output logic [1:0]                     O_BRESP,
  input  wire logic                      I_ARVALID,
  output logic                           O_ARREADY,
  input  wire logic [phy_mac_pkg::ADDR_W-1:0] I_ARADDR,
  output logic                           O_RVALID,
  input  wire logic                      I_RREADY,
  output logic [phy_mac_pkg::DATA_W-1:0] O_RDATA,
  output logic [1:0]                     O_RRESP,
  output logic                           O_IRQ,
  // reset pin and straps
  input  wire logic                      I_RESET_N_PIN,
  input  wire logic                      I_MAC_SIDE_FLOAT_STRAP,
  input  wire logic                      I_SERIAL_10M_MODE_STRAP,
  input  wire logic                      I_RMII_STRAP,
  input  wire logic                      I_REPEATER_STRAP,
  // mac transmit pins and their gated copies to the core
  input  wire logic [3:0]                I_TXD,
  input  wire logic                      I_TX_EN,
  input  wire logic                      I_TX_ER,
  output logic [3:0]                     O_TXD,
  output logic                           O_TX_EN,
  output logic                           O_TX_ER,
  // medium side, from the phy core
  input  wire logic                      I_RX_MEDIUM_ACTIVE,
  input  wire logic                      I_RX_DATA_VALID,
  input  wire logic                      I_RX_ERROR_DETECT,
  input  wire logic                      I_CARRIER_PRESENT,
  input  wire logic                      I_COLLISION_PRESENT,
  // mac-side outputs with enables
  output logic                           O_RX_DV,
  output logic                           O_RX_DV_OE,
  output logic                           O_RECEIVE_ERROR_OUT,
  output logic                           O_RECEIVE_ERROR_OUT_OE,
  output logic                           O_COL,
  output logic                           O_COL_OE,
  output logic                           O_CRS,
  output logic                           O_CRS_OE
);

  import phy_mac_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic         rst_pin_n;
  strap_t       strap_pin;
  logic [5:0]   tx_pin;

  pin_sync3 #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_d     (I_RESET_N_PIN),
    .o_q     (rst_pin_n)
  );

  pin_sync3 #(.WIDTH(4), .INIT(1'b0)) u_strap_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_d     ({I_REPEATER_STRAP, I_SERIAL_10M_MODE_STRAP, I_RMII_STRAP,
               I_MAC_SIDE_FLOAT_STRAP}),
    .o_q     (strap_pin)
  );

  pin_sync3 #(.WIDTH(6), .INIT(1'b0)) u_tx_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_d     ({I_TX_ER, I_TX_EN, I_TXD}),
    .o_q     (tx_pin)
  );

  // ---------------------------------------------------------------
  // device reset and strap capture
  // ---------------------------------------------------------------
  logic                   in_reset;
  logic                   in_reset_reg;
  strap_t                 strap_reg;
  if_mode_t               mode;
  logic [RESET_CNT_W-1:0] rst_cnt_reg;
  logic                   long_rst_reg;

  assign in_reset = I_RESET | ~rst_pin_n;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      in_reset_reg <= 1'b1;
    end else begin
      in_reset_reg <= in_reset;
    end
  end

  // straps follow the pins only while the pin reset is low
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      strap_reg <= STRAP_RESET;
    end else if (!rst_pin_n) begin
      strap_reg <= strap_pin;
    end
  end

  // reports whether the last pin reset lasted long enough
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      rst_cnt_reg  <= '0;
      long_rst_reg <= 1'b0;
    end else if (!rst_pin_n) begin
      if (rst_cnt_reg < RESET_CNT_W'(RESET_HOLD)) begin
        rst_cnt_reg <= rst_cnt_reg + 1'b1;
      end
      long_rst_reg <= (rst_cnt_reg >= RESET_CNT_W'(RESET_HOLD - 1));
    end else begin
      rst_cnt_reg <= '0;
    end
  end

  always_comb begin
    if (strap_reg.rmii) begin
      mode = MODE_RMII;
    end else if (strap_reg.serial) begin
      mode = MODE_SERIAL;
    end else begin
      mode = MODE_MII;
    end
  end

  // ---------------------------------------------------------------
  // transmit input gating
  // ---------------------------------------------------------------
  logic       tx_en_live;
  logic [3:0] txd_reg;
  logic       tx_en_reg;
  logic       tx_er_reg;

  assign tx_en_live = tx_pin[4] & ~strap_reg.float_out;

  always_ff @(posedge I_CLK) begin
    if (in_reset || strap_reg.float_out) begin
      txd_reg   <= 4'h0;
      tx_en_reg <= 1'b0;
      tx_er_reg <= 1'b0;
    end else begin
      txd_reg   <= tx_pin[3:0];
      tx_en_reg <= tx_pin[4];
      tx_er_reg <= tx_pin[5];
    end
  end

  // ---------------------------------------------------------------
  // mac-side status outputs
  // ---------------------------------------------------------------
  logic       full_duplex;
  mac_out_t   out_reg;
  mac_out_t   out_next;
  logic       err_hold_reg;
  logic       dv_now;
  logic       out_en;
  logic [31:0] ctrl_reg;

  assign full_duplex = ctrl_reg[CTRL_FULL_DUPLEX_BIT];

  always_comb begin
    unique case (mode)
      MODE_MII:    dv_now = I_RX_DATA_VALID;
      MODE_RMII:   dv_now = I_RX_MEDIUM_ACTIVE;
      MODE_SERIAL: dv_now = 1'b0;
    endcase
  end

  // sticky error: set only while data valid is high, released when it drops
  always_ff @(posedge I_CLK) begin
    if (in_reset) begin
      err_hold_reg <= 1'b0;
    end else if (mode == MODE_SERIAL) begin
      err_hold_reg <= 1'b0;
    end else if (I_RX_ERROR_DETECT && dv_now) begin
      err_hold_reg <= 1'b1;
    end else if (!dv_now) begin
      err_hold_reg <= 1'b0;
    end
  end

  always_comb begin
    out_next        = MAC_OUT_RESET;
    out_next.rx_dv  = dv_now;
    out_next.rx_err = dv_now & (err_hold_reg | I_RX_ERROR_DETECT) & (mode != MODE_SERIAL);
    if (mode != MODE_RMII && !full_duplex) begin
      out_next.col = I_COLLISION_PRESENT;
      out_next.crs = I_CARRIER_PRESENT | (tx_en_live & ~strap_reg.repeater);
    end else if (mode != MODE_RMII) begin
      out_next.col = 1'b0;
      out_next.crs = I_CARRIER_PRESENT;
    end
  end

  // carrier is retimed to the core clock only, never to a receive clock
  always_ff @(posedge I_CLK) begin
    if (in_reset || strap_reg.float_out) begin
      out_reg <= MAC_OUT_RESET;
    end else begin
      out_reg <= out_next;
    end
  end

  assign out_en                 = ~in_reset_reg & ~strap_reg.float_out;
  assign O_RX_DV                = out_reg.rx_dv;
  assign O_RX_DV_OE             = out_en;
  assign O_RECEIVE_ERROR_OUT    = out_reg.rx_err;
  assign O_RECEIVE_ERROR_OUT_OE = out_en & (mode != MODE_SERIAL);
  assign O_COL                  = out_reg.col;
  assign O_COL_OE               = out_en & (mode != MODE_RMII);
  assign O_CRS                  = out_reg.crs;
  assign O_CRS_OE               = out_en & (mode != MODE_RMII);
  assign O_TXD                  = txd_reg;
  assign O_TX_EN                = tx_en_reg;
  assign O_TX_ER                = tx_er_reg;

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;
  mac_out_t         out_prev_reg;

  always_ff @(posedge I_CLK) begin
    if (in_reset) begin
      out_prev_reg <= MAC_OUT_RESET;
    end else begin
      out_prev_reg <= out_reg;
    end
  end

  always_comb begin
    irq_event                 = '0;
    irq_event[IRQ_RX_ERR_BIT] = out_reg.rx_err & ~out_prev_reg.rx_err;
    irq_event[IRQ_COL_BIT]    = out_reg.col & ~out_prev_reg.col;
    irq_event[IRQ_CRS_BIT]    = out_reg.crs & ~out_prev_reg.crs;
    irq_event[IRQ_STRAP_BIT]  = in_reset_reg & ~in_reset;
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  logic                aw_full_reg;
  logic [ADDR_W-1:0]   aw_addr_reg;
  logic                w_full_reg;
  logic [DATA_W-1:0]   w_data_reg;
  logic [3:0]          w_strb_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                do_write;
  logic [DATA_W-1:0]   w_mask;

  assign O_AWREADY = ~aw_full_reg;
  assign O_WREADY  = ~w_full_reg;
  assign do_write  = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign w_mask    = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                      {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign irq_clear = (do_write && aw_addr_reg == IRQ_STAT_OFFSET)
                     ? (w_data_reg[IRQ_W-1:0] & w_mask[IRQ_W-1:0]) : '0;

  // address and data are taken in either order and held until the write
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (I_AWVALID && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= I_AWADDR;
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= 4'h0;
    end else if (I_WVALID && !w_full_reg) begin
      w_full_reg <= 1'b1;
      w_data_reg <= I_WDATA;
      w_strb_reg <= I_WSTRB;
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      unique case (aw_addr_reg)
        CTRL_OFFSET, STRAP_OFFSET, LINE_OFFSET,
        IRQ_STAT_OFFSET, IRQ_MASK_OFFSET: bresp_reg <= RESP_OKAY;
        default: bresp_reg <= RESP_SLVERR;
      endcase
    end else if (I_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      ctrl_reg <= CTRL_RESET;
    end else if (do_write && aw_addr_reg == CTRL_OFFSET) begin
      ctrl_reg <= (ctrl_reg & ~w_mask) | (w_data_reg & w_mask & 32'h0000_0001);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      irq_mask_reg <= IRQ_RESET;
    end else if (do_write && aw_addr_reg == IRQ_MASK_OFFSET) begin
      irq_mask_reg <= (irq_mask_reg & ~w_mask[IRQ_W-1:0])
                    | (w_data_reg[IRQ_W-1:0] & w_mask[IRQ_W-1:0]);
    end
  end

  // an event in the clearing cycle survives the clear
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      irq_stat_reg <= IRQ_RESET;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_event;
    end
  end

  assign O_BVALID = bvalid_reg;
  assign O_BRESP  = bresp_reg;
  assign O_IRQ    = |(irq_stat_reg & irq_mask_reg);

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  logic              rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0]        rresp_reg;

  assign O_ARREADY = ~rvalid_reg;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (I_ARVALID && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
      unique case (I_ARADDR)
        CTRL_OFFSET:     rdata_reg <= ctrl_reg;
        STRAP_OFFSET: begin
          rdata_reg[3:0]                           <= strap_reg;
          rdata_reg[STRAP_MODE_LSB+2:STRAP_MODE_LSB] <= mode;
          rdata_reg[STRAP_LONG_RST_BIT]            <= long_rst_reg;
        end
        LINE_OFFSET:     rdata_reg[4:0] <= {in_reset_reg, out_reg};
        IRQ_STAT_OFFSET: rdata_reg[IRQ_W-1:0] <= irq_stat_reg;
        IRQ_MASK_OFFSET: rdata_reg[IRQ_W-1:0] <= irq_mask_reg;
        default:         rresp_reg <= RESP_SLVERR;
      endcase
    end else if (I_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign O_RVALID = rvalid_reg;
  assign O_RDATA  = rdata_reg;
  assign O_RRESP  = rresp_reg;

endmodule

`default_nettype wire

// *** tb/phy_mac_side_assertions.sv ***
/*
  port-level checker for phy_mac_side, bound to every instance.
  assumes the design's own clock and synchronous reset; sees only top ports.
*/
`timescale 1ns/1ps
`default_nettype none
module phy_mac_side_checker (
  input wire logic        I_CLK,
  input wire logic        I_RESET,
  input wire logic        I_BREADY,
  input wire logic        I_RREADY,
  input wire logic        I_CARRIER_PRESENT,
  input wire logic        I_COLLISION_PRESENT,
  input wire logic        O_BVALID,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_RVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_TX_EN,
  input wire logic        O_RX_DV,
  input wire logic        O_RX_DV_OE,
  input wire logic        O_RECEIVE_ERROR_OUT,
  input wire logic        O_COL,
  input wire logic        O_COL_OE,
  input wire logic        O_CRS,
  input wire logic        O_CRS_OE
);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);
  chk_err_needs_dv: assert property (O_RECEIVE_ERROR_OUT |-> O_RX_DV)
    else $error("receive error high without data valid");
  chk_err_sticky: assert property (O_RECEIVE_ERROR_OUT ##1 O_RX_DV |-> O_RECEIVE_ERROR_OUT)
    else $error("receive error dropped while data valid high");
  chk_col_crs_oe: assert property (O_COL_OE == O_CRS_OE)
    else $error("collision and carrier enables differ");
  chk_undriven_quiet: assert property (!O_COL_OE |-> !O_COL && !O_CRS)
    else $error("collision or carrier high while undriven");
  chk_col_cause: assert property (O_COL |-> $past(I_COLLISION_PRESENT))
    else $error("collision without collision on medium");
  chk_crs_carrier: assert property ($past(I_CARRIER_PRESENT) && $past(O_CRS_OE) && O_CRS_OE |-> O_CRS)
    else $error("carrier present but carrier sense low");
  chk_float_tx: assert property (!O_RX_DV_OE && !O_COL_OE |-> !O_TX_EN)
    else $error("transmit enable passed while outputs floating");
  chk_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response not held");
  chk_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data not held");
  cov_err_held: cover property (O_RECEIVE_ERROR_OUT [*2]);
  cov_col: cover property (O_COL);
  cov_crs_only: cover property (O_CRS && !O_COL);
  cov_read: cover property (O_RVALID && I_RREADY);
endmodule

bind phy_mac_side phy_mac_side_checker i_chk (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_BREADY(I_BREADY), .I_RREADY(I_RREADY),
  .I_CARRIER_PRESENT(I_CARRIER_PRESENT), .I_COLLISION_PRESENT(I_COLLISION_PRESENT),
  .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA),
  .O_TX_EN(O_TX_EN), .O_RX_DV(O_RX_DV), .O_RX_DV_OE(O_RX_DV_OE),
  .O_RECEIVE_ERROR_OUT(O_RECEIVE_ERROR_OUT), .O_COL(O_COL), .O_COL_OE(O_COL_OE),
  .O_CRS(O_CRS), .O_CRS_OE(O_CRS_OE));
`default_nettype wire

// *** tb/mac_port_model.sv ***
/*
  behavioural mac: reset pin controller and transmit frame source.
  assumes one clock shared with the bench; straps are set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module mac_port_model #(
  parameter int HOLD = 8
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_go,
  input  wire logic       i_tx_go,
  input  wire logic       i_tx_err,
  output logic            o_reset_n,
  output logic [3:0]      o_txd = 4'h0,
  output logic            o_tx_en = 1'b0,
  output logic            o_tx_er = 1'b0
);
  // ---------------------------------------------------------------
  // reset pin and frames
  // ---------------------------------------------------------------
  int rst_cnt = HOLD;
  int tx_cnt = 0;
  logic in_frame;
  assign in_frame = i_tx_go || (tx_cnt > 1);
  // power-on starts low; released only after the hold count
  assign o_reset_n = (rst_cnt == 0);
  always @(posedge i_clk) begin
    if (i_rst_go) rst_cnt <= HOLD;
    else if (rst_cnt > 0) rst_cnt <= rst_cnt - 1;
    if (i_tx_go) tx_cnt <= 10;
    else if (tx_cnt > 0) tx_cnt <= tx_cnt - 1;
    o_tx_en <= in_frame;
    o_tx_er <= in_frame && i_tx_err;
    // released data lines wander so stale values never pass
    o_txd <= in_frame ? o_txd + 4'h1 : ~o_txd;
  end
endmodule
`default_nettype wire

// *** tb/tb_phy_mac_side.sv ***
/*
  self-checking bench for phy_mac_side: axi4-lite tasks, straps, medium levels.
  assumes the mac model drives the reset pin and transmit pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_phy_mac_side;
  import phy_mac_pkg::*;
  localparam int HOLD = 8;
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0;
  logic        arv = 1'b0, rre = 1'b0, rst_go = 1'b0, tx_go = 1'b0, tx_err = 1'b1;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [3:0]  strap = 4'h0, txd, txd_o;
  logic [4:0]  med = 5'h00; // col, carrier, error, valid, active
  logic [1:0]  br, rr, r;
  logic        aw_r, w_r, bv, ar_r, rv, irq, rst_n, tx_en, tx_er, tx_en_o, tx_er_o;
  logic        dv, dv_oe, er, er_oe, col, col_oe, crs, crs_oe;
  int          err_total = 0, check_count = 0, cyc = 0;
  always #50 clk = ~clk;
  phy_mac_side #(.RESET_HOLD(HOLD)) i_dut (
    .I_CLK(clk), .I_RESET(rst), .I_AWVALID(awv), .O_AWREADY(aw_r), .I_AWADDR(awa),
    .I_WVALID(wv), .O_WREADY(w_r), .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv),
    .I_BREADY(bre), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(ar_r), .I_ARADDR(ara),
    .O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rdat), .O_RRESP(rr), .O_IRQ(irq),
    .I_RESET_N_PIN(rst_n), .I_MAC_SIDE_FLOAT_STRAP(strap[0]), .I_RMII_STRAP(strap[1]),
    .I_SERIAL_10M_MODE_STRAP(strap[2]), .I_REPEATER_STRAP(strap[3]), .I_TXD(txd),
    .I_TX_EN(tx_en), .I_TX_ER(tx_er), .O_TXD(txd_o), .O_TX_EN(tx_en_o), .O_TX_ER(tx_er_o),
    .I_RX_MEDIUM_ACTIVE(med[0]), .I_RX_DATA_VALID(med[1]), .I_RX_ERROR_DETECT(med[2]),
    .I_CARRIER_PRESENT(med[3]), .I_COLLISION_PRESENT(med[4]), .O_RX_DV(dv),
    .O_RX_DV_OE(dv_oe), .O_RECEIVE_ERROR_OUT(er), .O_RECEIVE_ERROR_OUT_OE(er_oe),
    .O_COL(col), .O_COL_OE(col_oe), .O_CRS(crs), .O_CRS_OE(crs_oe));
  mac_port_model #(.HOLD(HOLD)) i_mac (
    .i_clk(clk), .i_rst_go(rst_go), .i_tx_go(tx_go), .i_tx_err(tx_err),
    .o_reset_n(rst_n), .o_txd(txd), .o_tx_en(tx_en), .o_tx_er(tx_er));
  // ---------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk4(input logic [3:0] g, input logic [3:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: pins %b expected %b", $time, g, e);
    end
  endtask
  // ready raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && aw_r) awv <= 1'b0;
      if (wv && w_r) wv <= 1'b0;
      if (n == 3) bre <= 1'b1;
    end while (!(bv && bre) && n < 50);
    r = br;
    bre <= 1'b0;
    if (n >= 50) err_total++;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && ar_r) arv <= 1'b0;
      if (n == 2) rre <= 1'b1;
    end while (!(rv && rre) && n < 50);
    d = rdat;
    r = rr;
    rre <= 1'b0;
    if (n >= 50) err_total++;
  endtask
  task automatic wait_pin(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic setm(input logic [4:0] m, input int n);
    @(posedge clk);
    med <= m;
    wait_pin(n);
  endtask
  task automatic txf;
    @(posedge clk);
    tx_go <= 1'b1;
    @(posedge clk);
    tx_go <= 1'b0;
    wait_pin(7);
  endtask
  // straps held well before and through the pin reset
  task automatic boot(input logic [3:0] s);
    @(posedge clk);
    strap <= s;
    repeat (6) @(posedge clk);
    rst_go <= 1'b1;
    @(posedge clk);
    rst_go <= 1'b0;
    repeat (30) @(posedge clk);
    rd(STRAP_OFFSET);
    chk32(d & 32'h7f, {25'h0, s[1] ? 3'h4 : (s[2] ? 3'h2 : 3'h1), s});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    boot(4'h0);
    rd(CTRL_OFFSET);
    chk32(d, CTRL_RESET);
    rd(IRQ_MASK_OFFSET);
    chk32(d, 32'h0);
    rd(8'h20);
    chk32({d[29:0], r}, {30'h0, RESP_SLVERR});
    rd(IRQ_STAT_OFFSET);
    chk4({2'h0, d[3], irq}, 4'h2);
    wr(IRQ_MASK_OFFSET, 32'h8);
    wait_pin(0);
    chk4({3'h0, irq}, 4'h1);
    wr(IRQ_STAT_OFFSET, 32'h8);
    wait_pin(0);
    chk4({3'h0, irq}, 4'h0);
    wr(STRAP_OFFSET, 32'hff);
    chk4({2'h0, r}, {2'h0, RESP_OKAY});
    rd(STRAP_OFFSET);
    chk32({23'h0, d[6:0], r}, {23'h0, 7'h10, RESP_OKAY});
    setm(5'b01000, 1);
    chk4({dv, er, col, crs}, 4'b0001);
    setm(5'b10000, 1);
    chk4({dv, er, col, crs}, 4'b0010);
    setm(5'b00110, 1);
    chk4({dv, er, col, crs}, 4'b1100);
    setm(5'b00010, 2);
    chk4({dv, er, col, crs}, 4'b1100);
    setm(5'b00000, 1);
    chk4({dv, er, col, crs}, 4'b0000);
    txf();
    chk4({tx_en_o, tx_er_o, crs, 1'b0}, 4'b1110);
    wait_pin(15);
    wr(CTRL_OFFSET, 32'h1);
    setm(5'b11000, 1);
    chk4({2'h0, col, crs}, 4'h1);
    setm(5'b00000, 1);
    txf();
    chk4({3'h0, crs}, 4'h0);
    wait_pin(15);
    wr(CTRL_OFFSET, 32'h0);
    boot(4'h8);
    txf();
    chk4({tx_en_o, 2'h0, crs}, 4'b1000);
    wait_pin(15);
    setm(5'b01000, 1);
    chk4({3'h0, crs}, 4'h1);
    boot(4'h6);
    chk4({col_oe, crs_oe, dv_oe, 1'b0}, 4'b0010);
    setm(5'b00101, 1);
    chk4({dv, er, col, crs}, 4'b1100);
    setm(5'b00001, 2);
    chk4({dv, er, col, crs}, 4'b1100);
    setm(5'b00000, 1);
    chk4({dv, er, col, crs}, 4'b0000);
    boot(4'h4);
    setm(5'b10110, 1);
    chk4({dv, er, col, er_oe}, 4'b0010);
    setm(5'b00000, 0);
    boot(4'h1);
    chk4({dv_oe, er_oe, col_oe, crs_oe}, 4'h0);
    txf();
    chk4({tx_en_o, tx_er_o, txd_o[1:0]}, 4'h0);
    wait_pin(15);
    boot(4'h0);
    @(posedge clk);
    rst_go <= 1'b1;
    @(posedge clk);
    rst_go <= 1'b0;
    wait_pin(6);
    chk4({dv_oe, er_oe, col_oe, crs_oe}, 4'h0);
    wait_pin(30);
    chk4({dv_oe, er_oe, col_oe, crs_oe}, 4'hf);
    stop_test();
  end
endmodule
`default_nettype wire
